// ### common/plcs_pkg.sv
package plcs_pkg;

   // ==========================================================
   // Register map
   localparam int        PLCS_AW          = 8;
   localparam logic [7:0] PLCS_OFS_LINK   = 8'hd0;
   localparam logic [7:0] PLCS_OFS_ISTAT  = 8'he0;
   localparam logic [7:0] PLCS_OFS_IMASK  = 8'he4;

   // ==========================================================
   // Control half, bit positions
   localparam int PLCS_B_ASPM    = 0;
   localparam int PLCS_B_BOUND   = 3;
   localparam int PLCS_B_DIS     = 4;
   localparam int PLCS_B_RETRAIN = 5;
   localparam int PLCS_B_CCLK    = 6;
   localparam int PLCS_B_XSYNC   = 7;
   localparam int PLCS_B_HAWD    = 9;
   localparam int PLCS_B_RSV     = 10;

   // ==========================================================
   // Status half, bit positions in the 32-bit word
   localparam int PLCS_B_SPEED   = 16;
   localparam int PLCS_B_WIDTH   = 20;
   localparam int PLCS_B_TERR    = 26;
   localparam int PLCS_B_TRAIN   = 27;
   localparam int PLCS_B_SLOT    = 28;
   localparam int PLCS_B_DLACT   = 29;

   // ==========================================================
   // Encodings and reset values
   localparam logic [1:0] PLCS_ASPM_OFF  = 2'h0;
   localparam logic [1:0] PLCS_ASPM_L0S  = 2'h1;
   localparam logic [1:0] PLCS_ASPM_L1   = 2'h2;
   localparam logic [1:0] PLCS_ASPM_BOTH = 2'h3;
   localparam logic [3:0] PLCS_SPEED_2G5 = 4'h1;
   localparam logic [3:0] PLCS_SPEED_5G0 = 4'h2;
   localparam logic [3:0] PLCS_SPEED_RST = PLCS_SPEED_5G0;
   localparam logic [5:0] PLCS_WIDTH_X2  = 6'h02;
   localparam logic [5:0] PLCS_WIDTH_X1  = 6'h01;
   localparam logic [1:0] PLCS_STRAP_FILL = 2'h3;

   // ==========================================================
   // Ordered set counts for extended synchronisation
   localparam logic [12:0] PLCS_FTS_EXT = 13'h1000;
   localparam logic [10:0] PLCS_TS1_EXT = 11'h400;

   // ==========================================================
   // Interrupt status layout
   localparam int PLCS_IRQ_W     = 3;
   localparam int PLCS_IRQ_TERR  = 0;
   localparam int PLCS_IRQ_TDONE = 1;
   localparam int PLCS_IRQ_DLCHG = 2;

   // ==========================================================
   // Carrier from the link training and data link logic
   typedef struct packed {
      logic       train_start;
      logic       train_fail;
      logic       l0_reached;
      logic [3:0] speed;
      logic [5:0] width;
      logic       dl_active;
   } plcs_lnk_in_t;

   // ==========================================================
   // Whole state of the block
   typedef struct packed {
      logic [1:0]            aspm;
      logic                  dis;
      logic                  cclk;
      logic                  xsync;
      logic                  hawd;
      logic [1:0]            rsv;
      logic [3:0]            speed;
      logic [5:0]            width;
      logic                  terr;
      logic                  training;
      logic                  slot_clk;
      logic                  dlact;
      logic [2:0]            strap_sync;
      logic [1:0]            strap_fill;
      logic                  strap_done;
      logic [PLCS_IRQ_W-1:0] istat;
      logic [PLCS_IRQ_W-1:0] imask;
      logic [31:0]           rdata;
      logic                  irq;
      logic                  retrain;
      logic [12:0]           fts;
      logic [10:0]           ts1;
      logic                  rx_l0s;
   } plcs_state_t;

endpackage : plcs_pkg

// ### logic/plcs_port_link.sv
`timescale 1ns/1ps
// Summary of operation
// [R01] The two-bit ASPM field means off, L0s, L1 or both, reset to off.
// [R02] The receive side may always enter L0s, whatever the ASPM field says.
// [R03] The read completion boundary bit is read-only and reads as zero.
// [R04] Link disable works only on a downstream port, is zero upstream.
// [R05] Writing one to retrain starts retraining on downstream ports only.
// [R06] The retrain bit always reads as zero.
// [R07] Common clock bit is read/write, reset zero, one means shared clock.
// [R08] Extended synch selects 4096 FTS and 1024 TS1 ordered sets on exit.
// [R09] Hardware autonomous width disable is read/write, reset zero.
// [R10] Bits 10 and 11 are zero upstream and read/write downstream.
// [R11] Negotiated speed reads 0001b or 0010b and resets to 0010b.
// [R12] Negotiated width is read-only, reset x2 on port 0, x1 elsewhere.
// [R13] Training error is set on failure, cleared on reaching L0.
// [R14] Training bit is one while training, cleared on completion, reset one.
// [R15] Slot clock bit resets from the strap pin, may be overridden.
// [R16] Data link active bit follows the DL_Active state.
// [R17] Retrain write gives a one-cycle pulse; disable is a held level.
module plcs_port_link
   import plcs_pkg::*;
#(
   parameter bit          DOWNSTREAM = 1'b1,
   parameter int          PORT_INDEX = 1,
   parameter logic [12:0] FTS_NORMAL = 13'h0080,
   parameter logic [10:0] TS1_NORMAL = 11'h010
) (
   input  wire logic               sys_clk,
   input  wire logic               rstn,
   input  wire logic [PLCS_AW-1:0] addr,
   input  wire logic [31:0]        wdata,
   input  wire logic               wr_en,
   input  wire logic               rd_en,
   output logic      [31:0]        rdata,
   output logic                    irq,
   input  wire plcs_lnk_in_t       lnk,
   input  wire logic               slot_clock_strap,
   input  wire logic               slot_clock_ovr_valid,
   input  wire logic               slot_clock_ovr_value,
   output logic                    link_disable,
   output logic                    retrain_req,
   output logic                    aspm_l0s_en,
   output logic                    aspm_l1_en,
   output logic                    rx_l0s_en,
   output logic                    common_clock,
   output logic                    hw_width_auto_dis,
   output logic      [1:0]         ctl_spare,
   output logic      [12:0]        fts_count,
   output logic      [10:0]        ts1_count
);

   // ==========================================================
   // Helpers
   localparam logic [5:0] WIDTH_RST = (PORT_INDEX == 0) ? PLCS_WIDTH_X2
                                                        : PLCS_WIDTH_X1;

   function automatic logic hit(input logic [PLCS_AW-1:0] a,
                                input logic [PLCS_AW-1:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   function automatic logic [31:0] link_word(input plcs_state_t st);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[PLCS_B_ASPM+:2]    = st.aspm;
      w[PLCS_B_DIS]        = st.dis;
      w[PLCS_B_CCLK]       = st.cclk;
      w[PLCS_B_XSYNC]      = st.xsync;
      w[PLCS_B_HAWD]       = st.hawd;
      w[PLCS_B_RSV+:2]     = st.rsv;
      w[PLCS_B_SPEED+:4]   = st.speed;
      w[PLCS_B_WIDTH+:6]   = st.width;
      w[PLCS_B_TERR]       = st.terr;
      w[PLCS_B_TRAIN]      = st.training;
      w[PLCS_B_SLOT]       = st.slot_clk;
      w[PLCS_B_DLACT]      = st.dlact;
      link_word = w;
   endfunction : link_word

   plcs_state_t           s;
   plcs_state_t           next_s;
   logic [PLCS_IRQ_W-1:0] ev;
   logic                  wr_link;
   logic                  rd_link;

   assign wr_link = wr_en && hit(addr, PLCS_OFS_LINK);
   assign rd_link = rd_en && hit(addr, PLCS_OFS_LINK);

   // ==========================================================
   // Next state
   always_comb begin
      next_s         = s;
      next_s.retrain = 1'b0;
      next_s.rdata   = 32'h0000_0000;
      next_s.rx_l0s  = 1'b1;                               // [R02]

      // Control half
      if (wr_link) begin
         next_s.aspm  = wdata[PLCS_B_ASPM+:2];             // [R01]
         next_s.cclk  = wdata[PLCS_B_CCLK];                // [R07]
         next_s.xsync = wdata[PLCS_B_XSYNC];
         next_s.hawd  = wdata[PLCS_B_HAWD];                // [R09]
         if (DOWNSTREAM) begin
            next_s.dis     = wdata[PLCS_B_DIS];            // [R04] [R17]
            next_s.rsv     = wdata[PLCS_B_RSV+:2];         // [R10]
            next_s.retrain = wdata[PLCS_B_RETRAIN];        // [R05] [R17]
         end
      end

      // Status half from the training logic; failure outranks start
      if (lnk.train_start) begin
         next_s.training = 1'b1;                           // [R14]
      end
      if (lnk.l0_reached) begin
         next_s.training = 1'b0;                           // [R14]
         next_s.terr     = 1'b0;                           // [R13]
         next_s.speed    = lnk.speed;                      // [R11]
         next_s.width    = lnk.width;                      // [R12]
      end
      if (lnk.train_fail) begin
         next_s.terr     = 1'b1;                           // [R13]
         next_s.training = 1'b0;                           // [R14]
      end
      next_s.dlact = lnk.dl_active;                        // [R16]

      // Strap is a pin: three stages, taken once two and three agree.
      // The reset zeros agree as well, so wait until every stage is filled.
      next_s.strap_sync = {s.strap_sync[1:0], slot_clock_strap};
      if (s.strap_fill != PLCS_STRAP_FILL) begin
         next_s.strap_fill = s.strap_fill + 2'h1;
      end
      if (!s.strap_done && (s.strap_fill == PLCS_STRAP_FILL)
          && (s.strap_sync[1] == s.strap_sync[2])) begin
         next_s.slot_clk   = s.strap_sync[2];              // [R15]
         next_s.strap_done = 1'b1;
      end
      if (slot_clock_ovr_valid) begin
         next_s.slot_clk   = slot_clock_ovr_value;         // [R15]
         next_s.strap_done = 1'b1;
      end

      // Interrupts: a new event wins over a clear in the same cycle
      ev                 = '0;
      ev[PLCS_IRQ_TERR]  = lnk.train_fail;
      ev[PLCS_IRQ_TDONE] = lnk.l0_reached;
      ev[PLCS_IRQ_DLCHG] = lnk.dl_active != s.dlact;
      if (wr_en && hit(addr, PLCS_OFS_ISTAT)) begin
         next_s.istat = s.istat & ~wdata[PLCS_IRQ_W-1:0];
      end
      if (wr_en && hit(addr, PLCS_OFS_IMASK)) begin
         next_s.imask = wdata[PLCS_IRQ_W-1:0];
      end
      next_s.istat = next_s.istat | ev;
      next_s.irq   = |(next_s.istat & next_s.imask);

      // Read data; retrain and boundary bits are never set in the word
      if (rd_link) begin
         next_s.rdata = link_word(s);                      // [R03] [R06]
      end else if (rd_en && hit(addr, PLCS_OFS_ISTAT)) begin
         next_s.rdata[PLCS_IRQ_W-1:0] = s.istat;
      end else if (rd_en && hit(addr, PLCS_OFS_IMASK)) begin
         next_s.rdata[PLCS_IRQ_W-1:0] = s.imask;
      end

      // Exit ordered set counts
      next_s.fts = next_s.xsync ? PLCS_FTS_EXT : FTS_NORMAL;  // [R08]
      next_s.ts1 = next_s.xsync ? PLCS_TS1_EXT : TS1_NORMAL;  // [R08]
   end

   // ==========================================================
   // State register
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         s            <= '0;
         s.aspm       <= PLCS_ASPM_OFF;                    // [R01]
         s.speed      <= PLCS_SPEED_RST;                   // [R11]
         s.width      <= WIDTH_RST;                        // [R12]
         s.training   <= 1'b1;                             // [R14]
         s.rx_l0s     <= 1'b1;                             // [R02]
         s.fts        <= FTS_NORMAL;
         s.ts1        <= TS1_NORMAL;
      end else begin
         s <= next_s;
      end
   end

   // ==========================================================
   // Outputs, all straight from the state register
   assign rdata             = s.rdata;
   assign irq               = s.irq;
   assign link_disable      = s.dis;                       // [R17]
   assign retrain_req       = s.retrain;
   assign aspm_l0s_en       = s.aspm[0];
   assign aspm_l1_en        = s.aspm[1];
   assign rx_l0s_en         = s.rx_l0s;
   assign common_clock      = s.cclk;
   assign hw_width_auto_dis = s.hawd;
   assign ctl_spare         = s.rsv;
   assign fts_count         = s.fts;
   assign ts1_count         = s.ts1;

   // ==========================================================
   // Checks
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);

   sequence seq_retrain_wr;
      wr_link && wdata[PLCS_B_RETRAIN] && DOWNSTREAM;
   endsequence

   sequence seq_one_pulse;
      retrain_req ##1 !retrain_req;
   endsequence

   sequence seq_fail;
      lnk.train_fail;
   endsequence

   sequence seq_good;
      lnk.l0_reached && !lnk.train_fail;
   endsequence

   chk_aspm_write: assert property ( // [R01]
      wr_link |=> aspm_l0s_en == $past(wdata[PLCS_B_ASPM])
               && aspm_l1_en == $past(wdata[PLCS_B_ASPM+1]))
      else $error("ASPM enables do not follow the written field");

   chk_rx_l0s_on: assert property ( // [R02]
      rx_l0s_en)
      else $error("Receive L0s entry blocked");

   chk_bound_zero: assert property ( // [R03]
      rd_link |=> !rdata[PLCS_B_BOUND])
      else $error("Completion boundary bit read as one");

   chk_disable_level: assert property ( // [R04]
      wr_link |=> link_disable == (DOWNSTREAM && $past(wdata[PLCS_B_DIS])))
      else $error("Link disable level wrong after write");

   chk_retrain_pulse: assert property ( // [R05]
      seq_retrain_wr |=> seq_one_pulse)
      else $error("Retrain request is not a single pulse");

   chk_retrain_reads: assert property ( // [R06]
      rd_link |=> !rdata[PLCS_B_RETRAIN])
      else $error("Retrain bit read as one");

   chk_cclk_write: assert property ( // [R07]
      wr_link |=> common_clock == $past(wdata[PLCS_B_CCLK]))
      else $error("Common clock bit not stored");

   chk_ext_sync: assert property ( // [R08]
      s.xsync |-> fts_count == PLCS_FTS_EXT && ts1_count == PLCS_TS1_EXT)
      else $error("Extended synch counts wrong");

   chk_upstream_spare: assert property ( // [R10]
      !DOWNSTREAM |-> ctl_spare == 2'h0 && !link_disable && !retrain_req)
      else $error("Upstream control bits not held at zero");

   chk_train_error: assert property ( // [R13]
      seq_fail |=> s.terr && !s.training)
      else $error("Training error not raised on failure");

   chk_train_done: assert property ( // [R14]
      seq_good |=> !s.terr && !s.training
                   && s.speed == $past(lnk.speed)
                   && s.width == $past(lnk.width))
      else $error("Training completion not recorded");

   chk_dl_active: assert property ( // [R16]
      rd_link ##1 1'b1 |-> rdata[PLCS_B_DLACT] == $past(lnk.dl_active, 2))
      else $error("Data link active bit does not follow the state");

   // ==========================================================
   // Checks on the register bus and interrupts
   sequence seq_stray_read;
      rd_en && !rd_link && !hit(addr, PLCS_OFS_ISTAT)
      && !hit(addr, PLCS_OFS_IMASK);
   endsequence

   chk_hawd_write: assert property ( // [R09]
      wr_link |=> hw_width_auto_dis == $past(wdata[PLCS_B_HAWD]))
      else $error("Width disable bit not stored");

   chk_spare_write: assert property ( // [R10]
      wr_link |=> ctl_spare == (DOWNSTREAM ? $past(wdata[PLCS_B_RSV+:2])
                                           : 2'h0))
      else $error("Spare control bits wrong after write");

   chk_disable_hold: assert property ( // [R17]
      !wr_link |=> $stable(link_disable) && $stable(common_clock))
      else $error("Link disable level moved without a write");

   chk_retrain_quiet: assert property ( // [R17]
      !(wr_link && wdata[PLCS_B_RETRAIN]) |=> !retrain_req)
      else $error("Retrain request without a write");

   chk_stray_read: assert property ( // [R03]
      seq_stray_read |=> rdata == 32'h0000_0000)
      else $error("Unmapped address read as nonzero");

   chk_rdata_idle: assert property ( // [R06]
      !rd_en |=> rdata == 32'h0000_0000)
      else $error("Read data stands outside a read");

   chk_mask_write: assert property ( // [R13]
      wr_en && hit(addr, PLCS_OFS_IMASK)
      |=> s.imask == $past(wdata[PLCS_IRQ_W-1:0]))
      else $error("Interrupt mask not stored");

   chk_istat_read: assert property ( // [R13]
      rd_en && hit(addr, PLCS_OFS_ISTAT)
      |=> rdata[PLCS_IRQ_W-1:0] == $past(s.istat))
      else $error("Interrupt status read back wrong");

   chk_istat_sticky: assert property ( // [R13]
      (|ev) |=> (s.istat & $past(ev)) == $past(ev))
      else $error("Event lost against a clear");

   chk_irq_level: assert property ( // [R13]
      irq == |(s.istat & s.imask))
      else $error("Interrupt output does not follow status and mask");

   // ==========================================================
   // Checks on the status half and the strap
   sequence seq_strap_agree;
      !s.strap_done && s.strap_fill == PLCS_STRAP_FILL
      && s.strap_sync[1] == s.strap_sync[2]
      && !slot_clock_ovr_valid;
   endsequence

   chk_train_start: assert property ( // [R14]
      lnk.train_start && !lnk.train_fail && !lnk.l0_reached |=> s.training)
      else $error("Training bit not raised at start");

   chk_tdone_event: assert property ( // [R14]
      lnk.l0_reached |=> s.istat[PLCS_IRQ_TDONE])
      else $error("Training completion event not recorded");

   chk_terr_event: assert property ( // [R13]
      seq_fail |=> s.istat[PLCS_IRQ_TERR])
      else $error("Training error event not recorded");

   chk_speed_hold: assert property ( // [R11] [R12]
      !lnk.l0_reached |=> $stable(s.speed) && $stable(s.width))
      else $error("Negotiated speed or width moved without training");

   chk_status_read: assert property ( // [R11] [R12]
      rd_link |=> rdata[PLCS_B_SPEED+:4] == $past(s.speed)
               && rdata[PLCS_B_WIDTH+:6] == $past(s.width))
      else $error("Negotiated speed or width read back wrong");

   chk_dl_change: assert property ( // [R16]
      lnk.dl_active != s.dlact |=> s.istat[PLCS_IRQ_DLCHG])
      else $error("Data link change event not recorded");

   chk_xsync_off: assert property ( // [R08]
      !s.xsync |-> fts_count == FTS_NORMAL && ts1_count == TS1_NORMAL)
      else $error("Normal ordered set counts wrong");

   chk_strap_take: assert property ( // [R15]
      seq_strap_agree
      |=> s.slot_clk == $past(s.strap_sync[2]))
      else $error("Slot clock bit did not take the strap");

   chk_ovr_take: assert property ( // [R15]
      slot_clock_ovr_valid |=> s.slot_clk == $past(slot_clock_ovr_value))
      else $error("Slot clock override not taken");

   chk_strap_once: assert property ( // [R15]
      s.strap_done && !slot_clock_ovr_valid |=> $stable(s.slot_clk))
      else $error("Slot clock bit moved after capture");

   chk_slot_read: assert property ( // [R15]
      rd_link |=> rdata[PLCS_B_SLOT] == $past(s.slot_clk))
      else $error("Slot clock bit read back wrong");

endmodule : plcs_port_link

// ### test/plcs_link_partner.sv
`timescale 1ns/1ps
// ==========================================================
// Link training and data link partner, behavioural
module plcs_link_partner
   import plcs_pkg::*;
#(
   parameter int LAT = 4
) (
   input  wire logic       sys_clk,
   input  wire logic       rstn,
   input  wire logic       retrain_req,
   input  wire logic       link_disable,
   input  wire logic [1:0] cmd,
   input  wire logic [3:0] spd,
   input  wire logic [5:0] wid,
   output plcs_lnk_in_t    lnk
);
   logic [LAT-1:0] rq;
   // Retrain is answered late, as a real training machine would
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         lnk <= '0;
         rq  <= '0;
      end else begin
         rq              <= {rq[LAT-2:0], retrain_req};
         lnk.train_start <= (cmd == 2'h3) || rq[LAT-1];
         lnk.train_fail  <= (cmd == 2'h1);
         lnk.l0_reached  <= (cmd == 2'h2);
         if (cmd == 2'h2) begin
            lnk.speed     <= spd;
            lnk.width     <= wid;
            lnk.dl_active <= !link_disable;
         end
         // A held disable keeps the data link down
         if (cmd == 2'h1 || link_disable)
            lnk.dl_active <= 1'b0;
      end
   end
endmodule : plcs_link_partner

// ### test/tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb;
   import plcs_pkg::*;
   localparam logic [12:0] FN = 13'h0080;
   localparam logic [10:0] TN = 11'h010;
   logic         sys_clk, rstn, wr_en, rd_en, strap, ovr_v, ovr_d;
   logic         irq, ld, rt, l0s_en, l1_en, rx_l0s, cclk, hwd, ld_up, rt_up;
   logic [7:0]   addr;
   logic [31:0]  wdata, rdata, rdata_up, d, w;
   logic [1:0]   cmd, spare;
   logic [3:0]   spd;
   logic [5:0]   wid;
   logic [12:0]  fts;
   logic [10:0]  ts1;
   plcs_lnk_in_t lnk;
   int           miscompares, compares, i;
   integer       seed;

   // ==========================================================
   // Downstream port under test, upstream port 0 beside it
   plcs_port_link #(.DOWNSTREAM(1'b1), .PORT_INDEX(1), .FTS_NORMAL(FN),
      .TS1_NORMAL(TN)) DUT (.sys_clk(sys_clk), .rstn(rstn), .addr(addr),
      .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
      .irq(irq), .lnk(lnk), .slot_clock_strap(strap),
      .slot_clock_ovr_valid(ovr_v), .slot_clock_ovr_value(ovr_d),
      .link_disable(ld), .retrain_req(rt), .aspm_l0s_en(l0s_en),
      .aspm_l1_en(l1_en), .rx_l0s_en(rx_l0s), .common_clock(cclk),
      .hw_width_auto_dis(hwd), .ctl_spare(spare), .fts_count(fts),
      .ts1_count(ts1));
   plcs_port_link #(.DOWNSTREAM(1'b0), .PORT_INDEX(0)) dut_up (
      .sys_clk(sys_clk), .rstn(rstn), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata_up), .irq(), .lnk(lnk),
      .slot_clock_strap(strap), .slot_clock_ovr_valid(ovr_v),
      .slot_clock_ovr_value(ovr_d), .link_disable(ld_up),
      .retrain_req(rt_up), .aspm_l0s_en(), .aspm_l1_en(), .rx_l0s_en(),
      .common_clock(), .hw_width_auto_dis(), .ctl_spare(), .fts_count(),
      .ts1_count());
   plcs_link_partner #(.LAT(4)) partner (.sys_clk(sys_clk), .rstn(rstn),
      .retrain_req(rt), .link_disable(ld), .cmd(cmd), .spd(spd),
      .wid(wid), .lnk(lnk));

   // ==========================================================
   // Bus and link tasks
   function automatic logic [31:0] expw(input logic [15:0] c,
      input logic [3:0] s, input logic [5:0] wd, input logic te, tr, sl);
      return {3'h0, sl, tr, te, wd, s, c};
   endfunction : expw

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      addr  <= a;
      wdata <= v;
      wr_en <= 1'b1;
      @(posedge sys_clk);
      wr_en <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge sys_clk);
      rd_en <= 1'b0;
      #1;
      d = rdata;
   endtask : rd

   // Partner events take two edges to reach the status bits
   task automatic ev(input logic [1:0] c);
      @(posedge sys_clk);
      cmd <= c;
      @(posedge sys_clk);
      cmd <= 2'h0;
      repeat (3) @(posedge sys_clk);
      #1;
   endtask : ev

   task automatic close_out;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : close_out

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   initial begin
      repeat (5000) @(posedge sys_clk);
      miscompares++;
      close_out;
   end

   // ==========================================================
   // Tests
   initial begin
      seed = 32'h126a2fe0;
      {rstn, wr_en, rd_en, ovr_v, ovr_d, addr, wdata, cmd} = '0;
      {strap, spd, wid} = {1'b1, PLCS_SPEED_RST, PLCS_WIDTH_X1};
      repeat (16) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (4) @(posedge sys_clk);
      #1;
      `CHK({rx_l0s, fts, ts1}, {1'b1, FN, TN})
      rd(PLCS_OFS_LINK);
      w = expw(16'h0, PLCS_SPEED_RST, PLCS_WIDTH_X1, 1'h0, 1'h1, 1'h1);
      `CHK(d, w)
      w[PLCS_B_WIDTH+:6] = PLCS_WIDTH_X2;
      `CHK(rdata_up, w)
      $display("test reset values done");
      for (i = 0; i < 12; i++) begin
         w = $random(seed);
         if (i == 0) w = 32'hffffffff;
         if (i == 1) w = 32'h0;
         w[1:0] = i[1:0];
         wr(PLCS_OFS_LINK, w);
         `CHK({l0s_en, l1_en, rx_l0s}, {w[0], w[1], 1'b1})
         `CHK({rt, ld, ld_up, rt_up}, {w[5], w[4], 2'h0})
         `CHK({cclk, hwd, spare}, {w[6], w[9], w[11:10]})
         `CHK(fts, w[7] ? PLCS_FTS_EXT : FN)
         `CHK(ts1, w[7] ? PLCS_TS1_EXT : TN)
         @(posedge sys_clk);
         #1;
         `CHK({rt, ld}, {1'b0, w[4]})
         rd(PLCS_OFS_LINK);
         `CHK(d[15:0], w[15:0] & 16'h0ed3)
         `CHK(rdata_up[15:0], w[15:0] & 16'h02c3)
      end
      wr(PLCS_OFS_LINK, 32'h0);
      $display("test control half done");
      wr(PLCS_OFS_IMASK, 32'h7);
      wr(PLCS_OFS_ISTAT, 32'h7);
      ev(2'h1);
      `CHK(irq, 1'b1)
      rd(PLCS_OFS_LINK);
      `CHK(d[29:26], 4'b0101)
      rd(PLCS_OFS_ISTAT);
      `CHK(d, 32'h1)
      wr(PLCS_OFS_ISTAT, 32'h1);
      @(posedge sys_clk);
      #1;
      `CHK(irq, 1'b0)
      for (i = 0; i < 2; i++) begin
         spd = i ? PLCS_SPEED_5G0 : PLCS_SPEED_2G5;
         wid = i ? PLCS_WIDTH_X2 : PLCS_WIDTH_X1;
         ev(2'h3);
         rd(PLCS_OFS_LINK);
         `CHK(d[27], 1'b1)
         ev(2'h2);
         rd(PLCS_OFS_LINK);
         `CHK(d[31:16], {4'h3, 2'h0, wid, spd})
      end
      rd(PLCS_OFS_ISTAT);
      `CHK(d, 32'h6)
      wr(PLCS_OFS_IMASK, 32'h0);
      @(posedge sys_clk);
      #1;
      `CHK(irq, 1'b0)
      wr(PLCS_OFS_ISTAT, 32'h7);
      wr(PLCS_OFS_LINK, 32'h10);
      ev(2'h0);
      rd(PLCS_OFS_LINK);
      `CHK({d[29], d[4], ld}, 3'b011)
      wr(8'hd4, 32'hffffffff);
      wr(PLCS_OFS_LINK, 32'h0);
      rd(8'hd4);
      `CHK(d, 32'h0)
      @(posedge sys_clk);
      {ovr_v, ovr_d} <= 2'b10;
      @(posedge sys_clk);
      ovr_v <= 1'b0;
      rd(PLCS_OFS_LINK);
      `CHK({d[28], d[15:0]}, 17'h0)
      $display("test link status done");
      wr(PLCS_OFS_LINK, 32'hffffffff);
      @(posedge sys_clk);
      rstn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (4) @(posedge sys_clk);
      #1;
      `CHK({ld, rt, l0s_en, l1_en, cclk, hwd, spare, irq}, 9'h0)
      rd(PLCS_OFS_LINK);
      w = expw(16'h0, PLCS_SPEED_RST, PLCS_WIDTH_X1, 1'h0, 1'h1, 1'h1);
      `CHK(d, w)
      $display("test second reset done");
      close_out;
   end
endmodule : tb
